// ### src/regctl_pkg.sv
// shared constants and carrier types for the regulator control register bank
package regctl_pkg;

  localparam int NUM_BUCK = 3;
  localparam int NUM_LDO  = 2;
  localparam int NUM_REG  = NUM_BUCK + NUM_LDO;
  localparam int VCODE_W  = 6;
  localparam int DELAY_W  = 3;
  localparam int BYTE_W   = 8;

  // register offsets, index 0 is converter a / ldo a
  localparam logic [7:0] BUCK_PRI_OFS [NUM_BUCK] = '{8'h20, 8'h30, 8'h40};
  localparam logic [7:0] BUCK_SEC_OFS [NUM_BUCK] = '{8'h21, 8'h31, 8'h41};
  localparam logic [7:0] BUCK_CTL_OFS [NUM_BUCK] = '{8'h22, 8'h32, 8'h42};
  localparam logic [7:0] LDO_VOLT_OFS [NUM_LDO]  = '{8'h50, 8'h54};
  localparam logic [7:0] LDO_CTL_OFS  [NUM_LDO]  = '{8'h51, 8'h55};

  // control register fields
  localparam int CTL_ON_BIT    = 7;
  localparam int CTL_PHASE_BIT = 6;
  localparam int CTL_BLEED_BIT = 6;
  localparam int CTL_MODE_BIT  = 5;
  localparam int CTL_LOWQ_BIT  = 5;
  localparam int CTL_DLY_MSB   = 4;
  localparam int CTL_DLY_LSB   = 2;
  localparam int CTL_IRQ_BIT   = 1;
  localparam int CTL_PGOOD_BIT = 0;

  // writable bits; bit 0 of control and bits 7:6 of voltage codes are not stored
  localparam logic [7:0] CTL_WMASK   = 8'hfe;
  localparam logic [7:0] VCODE_WMASK = 8'h3f;

  // converter c has no phase control, its bit 6 is plain storage
  localparam logic [NUM_BUCK-1:0] BUCK_HAS_PHASE = 3'b011;

  // serial protocol
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK  = 4'h9;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_REG, PH_WDATA, PH_RDATA} phase_t;

  typedef struct packed {
    logic [VCODE_W-1:0] vcode;
    logic               on;
    logic               phase_shift;
    logic               force_pwm;
    logic [DELAY_W-1:0] delay;
  } buck_out_t;

  typedef struct packed {
    logic [VCODE_W-1:0] vcode;
    logic               on;
    logic               bleed_active;
    logic               low_quiescent_select;
    logic [DELAY_W-1:0] delay;
  } ldo_out_t;

endpackage

// ### src/sync2.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync2 needs at least one bit");
  end

  // the first stage feeds nothing but the second
  always_comb begin
    next_s        = s;
    next_s.meta   = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule
`default_nettype wire

// ### src/fault_watch.sv
// per-regulator fault event on loss of power-good
`timescale 1ns/1ps
`default_nettype none
module fault_watch (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pgood,
  input  wire logic enabled,
  input  wire logic irq_enable,
  output logic      fault_pulse
);

  typedef struct packed {
    logic prev_good;
    logic pulse;
  } watch_state_t;

  watch_state_t s;
  watch_state_t next_s;

  always_comb begin
    next_s           = s;
    next_s.prev_good = pgood;
    // the enable bit gates the event, the flag itself still reads live
    next_s.pulse     = s.prev_good & ~pgood & enabled & irq_enable;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fault_pulse = s.pulse;

endmodule
`default_nettype wire

// ### src/regulator_control_regs.sv
// regulator control and status registers behind the two-wire serial port
`timescale 1ns/1ps
`default_nettype none
module regulator_control_regs #(
  parameter logic [6:0]                   DEV_ADDR      = 7'h5b,
  parameter logic [7:0]                   CTL_DEFAULT   = 8'h00,
  parameter logic [regctl_pkg::VCODE_W-1:0] VCODE_DEFAULT = 6'h00
) (
  input  wire logic                                            mclk,
  input  wire logic                                            rstn,
  input  wire logic                                            scl_in,
  input  wire logic                                            sda_in,
  output logic                                                 sda_out,
  output logic                                                 sda_oe_n,
  input  wire logic                                            voltage_bank_select_pin,
  input  wire logic [regctl_pkg::NUM_REG-1:0]                  power_good,
  input  wire logic                                            undervoltage,
  output regctl_pkg::buck_out_t [regctl_pkg::NUM_BUCK-1:0]     buck,
  output regctl_pkg::ldo_out_t  [regctl_pkg::NUM_LDO-1:0]      ldo,
  output logic [regctl_pkg::NUM_REG-1:0]                       fault_event
);
  import regctl_pkg::*;

  localparam int SYNC_W = NUM_REG + 4;

  typedef struct packed {
    phase_t                           phase;
    logic                             rw;
    logic                             mack;
    logic [3:0]                       cnt;
    logic [7:0]                       shreg;
    logic [7:0]                       ptr;
    logic                             drv;
    logic                             scl_q;
    logic                             sda_q;
    logic [NUM_BUCK-1:0][7:0]         pri;
    logic [NUM_BUCK-1:0][7:0]         sec;
    logic [NUM_BUCK-1:0][7:0]         bctl;
    logic [NUM_LDO-1:0][7:0]          lvolt;
    logic [NUM_LDO-1:0][7:0]          lctl;
    buck_out_t [NUM_BUCK-1:0]         bo;
    ldo_out_t  [NUM_LDO-1:0]          lo;
  } state_t;

  state_t                   s;
  state_t                   next_s;
  logic [1:0]               rst_pipe;
  logic                     rst_n;
  logic [SYNC_W-1:0]        sync_raw;
  logic [SYNC_W-1:0]        sync_val;
  logic                     sy_scl;
  logic                     sy_sda;
  logic                     sy_voltage_bank_select_pin;
  logic                     sy_uvlo;
  logic [NUM_REG-1:0]       sy_pgood;
  logic [NUM_REG-1:0][7:0]  all_ctl;

  if (CTL_DEFAULT[CTL_PGOOD_BIT] != 1'b0) begin : g_bad_ctl_default
    $error("control default must leave the status bit clear");
  end
  if (DEV_ADDR == 7'h00) begin : g_bad_addr
    $error("device address must not be the general call address");
  end
  // the logic assumes at least one regulator of each kind
  if (NUM_BUCK < 1 || NUM_LDO < 1) begin : g_bad_counts
    $error("bank needs at least one converter and one ldo");
  end
  // reserved code bits are forced by masking, so the code plus two reserved bits must fill one byte exactly
  if (VCODE_W + 2 != BYTE_W) begin : g_bad_vcode_w
    $error("voltage code must leave exactly two reserved bits");
  end
  if (CTL_DLY_MSB - CTL_DLY_LSB + 1 != DELAY_W) begin : g_bad_delay
    $error("delay field width does not match its bit positions");
  end
  if ((CTL_DEFAULT & ~CTL_WMASK) != 8'h00) begin : g_bad_ctl_mask
    $error("control default sets bits that are never stored");
  end
  // overlapping slots would let one write land in two registers
  for (genvar i = 0; i < NUM_BUCK; i++) begin : g_buck_ofs_check
    if (BUCK_PRI_OFS[i] == BUCK_CTL_OFS[i]
        || BUCK_SEC_OFS[i] == BUCK_CTL_OFS[i]
        || BUCK_PRI_OFS[i] == BUCK_SEC_OFS[i]) begin : g_clash
      $error("converter register offsets overlap");
    end
  end
  for (genvar i = 0; i < NUM_LDO; i++) begin : g_ldo_ofs_check
    if (LDO_VOLT_OFS[i] == LDO_CTL_OFS[i]) begin : g_clash
      $error("ldo register offsets overlap");
    end
  end

  // reset is applied at once but released only after two clean edges
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  assign sync_raw = {undervoltage, power_good, voltage_bank_select_pin, sda_in, scl_in};

  sync2 #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (sync_raw),
    .sync_out (sync_val)
  );

  assign sy_scl   = sync_val[0];
  assign sy_sda   = sync_val[1];
  assign sy_voltage_bank_select_pin  = sync_val[2];
  assign sy_pgood = sync_val[NUM_REG+2:3];
  assign sy_uvlo  = sync_val[SYNC_W-1];

  // read view of the bank; unmapped offsets read zero
  function automatic logic [7:0] read_reg(input state_t st, input logic [7:0] addr,
                                          input logic [NUM_REG-1:0] pg);
    logic [7:0] rd;
    rd = 8'h00;
    for (int k = 0; k < NUM_BUCK; k++) begin
      if (addr == BUCK_PRI_OFS[k]) begin
        rd = st.pri[k] & VCODE_WMASK;
      end
      if (addr == BUCK_SEC_OFS[k]) begin
        rd = st.sec[k] & VCODE_WMASK;
      end
      if (addr == BUCK_CTL_OFS[k]) begin
        rd = (st.bctl[k] & CTL_WMASK) | {7'h00, pg[k]};
      end
    end
    for (int k = 0; k < NUM_LDO; k++) begin
      if (addr == LDO_VOLT_OFS[k]) begin
        rd = st.lvolt[k] & VCODE_WMASK;
      end
      if (addr == LDO_CTL_OFS[k]) begin
        rd = (st.lctl[k] & CTL_WMASK) | {7'h00, pg[NUM_BUCK+k]};
      end
    end
    return rd;
  endfunction

  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       wr;
    logic [7:0] rd;
    next_s     = s;
    wr         = 1'b0;
    rd         = 8'h00;
    scl_rise   = sy_scl & ~s.scl_q;
    scl_fall   = ~sy_scl & s.scl_q;
    start_cond = sy_scl & s.scl_q & s.sda_q & ~sy_sda;
    stop_cond  = sy_scl & s.scl_q & ~s.sda_q & sy_sda;
    next_s.scl_q = sy_scl;
    next_s.sda_q = sy_sda;

    // serial protocol: address, register pointer, then data bytes
    if (start_cond) begin
      next_s.phase = PH_ADDR;
      next_s.cnt   = 4'h0;
      next_s.drv   = 1'b0;
    end else if (stop_cond) begin
      next_s.phase = PH_IDLE;
      next_s.drv   = 1'b0;
    end else if (s.phase != PH_IDLE) begin
      if (scl_rise) begin
        next_s.cnt = s.cnt + 4'h1;
        if (s.phase != PH_RDATA && s.cnt < BIT_LAST) begin
          next_s.shreg = {s.shreg[6:0], sy_sda};
        end
        if (s.phase == PH_RDATA && s.cnt == BIT_LAST) begin
          next_s.mack = ~sy_sda;
        end
      end else if (scl_fall) begin
        if (s.cnt == BIT_LAST) begin
          unique case (s.phase)
            PH_ADDR: begin
              if (s.shreg[7:1] == DEV_ADDR) begin
                next_s.drv = 1'b1;
                next_s.rw  = s.shreg[0];
              end else begin
                next_s.phase = PH_IDLE;
              end
            end
            PH_REG: begin
              next_s.drv = 1'b1;
              next_s.ptr = s.shreg;
            end
            PH_WDATA: begin
              next_s.drv = 1'b1;
              next_s.ptr = s.ptr + 8'h01;
              wr         = 1'b1;
            end
            PH_RDATA: begin
              next_s.drv = 1'b0;
            end
            PH_IDLE: begin
              next_s.phase = PH_IDLE;
            end
          endcase
        end else if (s.cnt == BIT_ACK) begin
          next_s.cnt = 4'h0;
          next_s.drv = 1'b0;
          if ((s.phase == PH_ADDR && s.rw) || (s.phase == PH_RDATA && s.mack)) begin
            rd           = read_reg(s, s.ptr, sy_pgood);
            next_s.phase = PH_RDATA;
            next_s.drv   = ~rd[7];
            next_s.shreg = {rd[6:0], 1'b0};
            next_s.ptr   = s.ptr + 8'h01;
          end else if (s.phase == PH_RDATA) begin
            next_s.phase = PH_IDLE;
          end else if (s.phase == PH_ADDR) begin
            next_s.phase = PH_REG;
          end else begin
            next_s.phase = PH_WDATA;
          end
        end else if (s.phase == PH_RDATA) begin
          next_s.drv   = ~s.shreg[7];
          next_s.shreg = {s.shreg[6:0], 1'b0};
        end
      end
    end

    // register writes; status and reserved code bits are never stored
    if (wr) begin
      for (int k = 0; k < NUM_BUCK; k++) begin
        if (s.ptr == BUCK_PRI_OFS[k]) begin
          next_s.pri[k] = s.shreg & VCODE_WMASK;
        end
        if (s.ptr == BUCK_SEC_OFS[k]) begin
          next_s.sec[k] = s.shreg & VCODE_WMASK;
        end
        if (s.ptr == BUCK_CTL_OFS[k]) begin
          next_s.bctl[k] = s.shreg & CTL_WMASK;
        end
      end
      for (int k = 0; k < NUM_LDO; k++) begin
        if (s.ptr == LDO_VOLT_OFS[k]) begin
          next_s.lvolt[k] = s.shreg & VCODE_WMASK;
        end
        if (s.ptr == LDO_CTL_OFS[k]) begin
          next_s.lctl[k] = s.shreg & CTL_WMASK;
        end
      end
    end

    // undervoltage wins over a write landing in the same cycle
    if (sy_uvlo) begin
      for (int k = 0; k < NUM_BUCK; k++) begin
        next_s.pri[k]  = {2'b00, VCODE_DEFAULT};
        next_s.sec[k]  = {2'b00, VCODE_DEFAULT};
        next_s.bctl[k] = CTL_DEFAULT;
      end
      for (int k = 0; k < NUM_LDO; k++) begin
        next_s.lvolt[k] = {2'b00, VCODE_DEFAULT};
        next_s.lctl[k]  = CTL_DEFAULT;
      end
    end

    // regulator controls, registered so the analog side sees clean levels
    for (int k = 0; k < NUM_BUCK; k++) begin
      next_s.bo[k].vcode = sy_voltage_bank_select_pin ? next_s.sec[k][VCODE_W-1:0]
                                   : next_s.pri[k][VCODE_W-1:0];
      next_s.bo[k].on          = next_s.bctl[k][CTL_ON_BIT];
      next_s.bo[k].phase_shift = next_s.bctl[k][CTL_PHASE_BIT] & BUCK_HAS_PHASE[k];
      next_s.bo[k].force_pwm   = next_s.bctl[k][CTL_MODE_BIT];
      next_s.bo[k].delay       = next_s.bctl[k][CTL_DLY_MSB:CTL_DLY_LSB];
    end
    for (int k = 0; k < NUM_LDO; k++) begin
      next_s.lo[k].vcode = next_s.lvolt[k][VCODE_W-1:0];
      next_s.lo[k].on    = next_s.lctl[k][CTL_ON_BIT];
      // discharge only while shut down, never fighting the regulator
      next_s.lo[k].bleed_active = next_s.lctl[k][CTL_BLEED_BIT]
                                  & ~next_s.lctl[k][CTL_ON_BIT];
      next_s.lo[k].low_quiescent_select = next_s.lctl[k][CTL_LOWQ_BIT];
      next_s.lo[k].delay = next_s.lctl[k][CTL_DLY_MSB:CTL_DLY_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.phase <= PH_IDLE;
      for (int k = 0; k < NUM_BUCK; k++) begin
        s.pri[k]  <= {2'b00, VCODE_DEFAULT};
        s.sec[k]  <= {2'b00, VCODE_DEFAULT};
        s.bctl[k] <= CTL_DEFAULT;
      end
      for (int k = 0; k < NUM_LDO; k++) begin
        s.lvolt[k] <= {2'b00, VCODE_DEFAULT};
        s.lctl[k]  <= CTL_DEFAULT;
      end
    end else begin
      s <= next_s;
    end
  end

  assign all_ctl = {s.lctl, s.bctl};

  for (genvar g = 0; g < NUM_REG; g++) begin : g_fault
    fault_watch u_watch (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .pgood       (sy_pgood[g]),
      .enabled     (all_ctl[g][CTL_ON_BIT]),
      .irq_enable  (all_ctl[g][CTL_IRQ_BIT]),
      .fault_pulse (fault_event[g])
    );
  end

  // open-drain: only ever pulls low
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~s.drv;
  assign buck     = s.bo;
  assign ldo      = s.lo;

endmodule
`default_nettype wire

// ### test/regctl_asserts.sv
// assertion checker for the regulator register bank ports
`timescale 1ns/1ps
`default_nettype none
module regctl_asserts (
  input wire logic                                        mclk,
  input wire logic                                        rstn,
  input wire logic                                        scl_in,
  input wire logic                                        sda_oe_n,
  input wire logic                                        voltage_bank_select_pin,
  input wire logic [regctl_pkg::NUM_REG-1:0]              power_good,
  input wire logic                                        undervoltage,
  input wire regctl_pkg::buck_out_t [regctl_pkg::NUM_BUCK-1:0] buck,
  input wire regctl_pkg::ldo_out_t  [regctl_pkg::NUM_LDO-1:0]  ldo,
  input wire logic [regctl_pkg::NUM_REG-1:0]              fault_event
);
  import regctl_pkg::*;
  // cycles with serial clock parked high and no lockout: no write can land
  logic [3:0] quiet;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) quiet <= '0;
    else if (!scl_in || undervoltage) quiet <= '0;
    else if (quiet != 4'hf) quiet <= quiet + 4'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence bus_quiet;
    quiet >= 4'h8;
  endsequence
  sequence uv_held;
    undervoltage [*5];
  endsequence
  sda_edge_a: assert property ($changed(sda_oe_n) |-> !$past(scl_in))
    else $error("data line moved while serial clock high");
  bank_follow_a: assert property (bus_quiet ##0 $changed({buck[0].vcode, buck[1].vcode,
    buck[2].vcode}) |-> $past(voltage_bank_select_pin, 3) != $past(voltage_bank_select_pin, 4))
    else $error("converter code moved without bank change");
  quiet_hold_a: assert property (bus_quiet |-> $stable(ldo)
    && $stable({buck[0][5:0], buck[1][5:0], buck[2][5:0]}))
    else $error("outputs moved with bus idle");
  bleed_off_a: assert property (!(ldo[0].bleed_active && ldo[0].on)
    && !(ldo[1].bleed_active && ldo[1].on))
    else $error("discharge active while regulator on");
  phase_c_a: assert property (!buck[2].phase_shift)
    else $error("converter c phase shifted");
  fault_buck_a: assert property (fault_event[0] |-> buck[0].on && !$past(power_good[0], 2))
    else $error("converter fault without cause");
  fault_ldo_a: assert property (fault_event[3] |-> ldo[0].on && !$past(power_good[3], 2))
    else $error("ldo fault without cause");
  fault_pulse_a: assert property (fault_event[0] |=> !fault_event[0])
    else $error("fault event longer than one cycle");
  uv_default_a: assert property (uv_held |-> buck == '0 && ldo == '0)
    else $error("outputs not default under lockout");
  reset_quiet_a: assert property (disable iff (1'b0) !rstn |-> sda_oe_n && fault_event == '0)
    else $error("outputs active in reset");
endmodule
bind regulator_control_regs regctl_asserts chk (.mclk(mclk), .rstn(rstn), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .voltage_bank_select_pin(voltage_bank_select_pin),
  .power_good(power_good), .undervoltage(undervoltage), .buck(buck), .ldo(ldo),
  .fault_event(fault_event));
`default_nettype wire

// ### test/i2c_host_model.sv
// two-wire bus host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] DEV = 7'h5b
) (
  input  wire logic mclk,
  input  wire logic sda_oe_n,
  output var logic  scl,
  output wire logic sda
);
  logic drv;
  // pull-up: the line is low when either party pulls it
  assign sda = drv & sda_oe_n;
  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // also serves as repeated start: release data, raise clock, then pull data
  task automatic start;
    tick(8);
    drv <= 1'b1;
    tick(8);
    scl <= 1'b1;
    tick(8);
    drv <= 1'b0;
    tick(8);
    scl <= 1'b0;
  endtask
  task automatic stop;
    tick(8);
    drv <= 1'b0;
    tick(8);
    scl <= 1'b1;
    tick(8);
    drv <= 1'b1;
    tick(16);
  endtask
  // data changes only mid clock-low, sampled mid clock-high
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(8);
      drv <= tx[i];
      tick(8);
      scl <= 1'b1;
      tick(8);
      rx[i] = sda;
      tick(8);
      scl <= 1'b0;
    end
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, dat, output logic ok);
    logic [8:0] a, b, c;
    start();
    xfer({dev, 2'b01}, a);
    xfer({ptr, 1'b1}, b);
    xfer({dat, 1'b1}, c);
    stop();
    ok = !a[0] && !b[0] && !c[0];
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] dat, output logic ok);
    logic [8:0] a, b, c, r;
    start();
    xfer({DEV, 2'b01}, a);
    xfer({ptr, 1'b1}, b);
    start();
    xfer({DEV, 2'b11}, c);
    xfer(9'h1ff, r);
    stop();
    dat = r[8:1];
    ok = !a[0] && !b[0] && !c[0];
  endtask
endmodule
`default_nettype wire

// ### test/test_regulator_control_regs.sv
// self-checking bench for the regulator register bank
`timescale 1ns/1ps
`default_nettype none
module test_regulator_control_regs;
  import regctl_pkg::*;
  localparam logic [6:0] DEV = 7'h5b; // arbitrary bus address
  localparam logic [7:0] CTL [5] = '{8'h22, 8'h32, 8'h42, 8'h51, 8'h55};
  logic                     mclk, rstn, bank, uv, ok;
  logic [NUM_REG-1:0]       pg, fev;
  wire logic                scl, sda, sda_oe_n;
  buck_out_t [NUM_BUCK-1:0] buck;
  ldo_out_t  [NUM_LDO-1:0]  ldo;
  logic [7:0]               rv;
  int                       n_errors, samples_checked, cyc;
  regulator_control_regs #(.DEV_ADDR(DEV)) dut (.mclk(mclk), .rstn(rstn), .scl_in(scl),
    .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n), .voltage_bank_select_pin(bank),
    .power_good(pg), .undervoltage(uv), .buck(buck), .ldo(ldo), .fault_event(fev));
  i2c_host_model #(.DEV(DEV)) host (.mclk(mclk), .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_ok(input logic [7:0] a, d);
    host.wr(DEV, a, d, ok);
    chk("write ack", 1, ok);
  endtask
  task automatic rchk(input logic [7:0] a, exp);
    host.rd(a, rv, ok);
    chk("read ack", 1, ok);
    chk("register", exp, rv);
  endtask
  task automatic t_ctl;
    pg <= '0;
    for (int k = 0; k < NUM_REG; k++) begin
      wr_ok(CTL[k], 8'hb7);
      rchk(CTL[k], 8'hb6);
    end
    chk("fields", {5{6'h2d}}, {buck[2][5:0], buck[1][5:0], buck[0][5:0], ldo[1][5:0],
      ldo[0][5:0]});
    pg <= '1;
    rchk(CTL[4], 8'hb7);
    $display("test control done");
  endtask
  task automatic t_vcode;
    for (int k = 0; k < NUM_BUCK; k++) begin
      wr_ok(CTL[k] - 8'h02, 8'hff);
      wr_ok(CTL[k] - 8'h01, 8'h15);
      rchk(CTL[k] - 8'h02, 8'h3f);
      chk("code low", 6'h3f, buck[k].vcode);
      bank <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("code high", 6'h15, buck[k].vcode);
      bank <= 1'b0;
    end
    for (int k = 3; k < NUM_REG; k++) begin
      wr_ok(CTL[k] - 8'h01, 8'hea);
      rchk(CTL[k] - 8'h01, 8'h2a);
      bank <= 1'b1;
      repeat (6) @(posedge mclk);
      chk("ldo code", 6'h2a, ldo[k-3].vcode);
      bank <= 1'b0;
    end
    $display("test codes done");
  endtask
  task automatic t_bleed;
    wr_ok(8'h51, 8'h60);
    chk("ldo off", 6'h18, ldo[0][5:0]);
    wr_ok(8'h51, 8'he0);
    chk("ldo on", 6'h28, ldo[0][5:0]);
    wr_ok(8'h42, 8'h40);
    chk("no phase", 6'h00, buck[2][5:0]);
    rchk(8'h42, 8'h41);
    wr_ok(8'h32, 8'h40);
    chk("phase", 6'h10, buck[1][5:0]);
    $display("test bleed done");
  endtask
  task automatic watch(input int k, input logic exp);
    logic seen;
    seen = 1'b0;
    pg[k] <= 1'b0;
    repeat (12) begin
      @(posedge mclk);
      seen |= fev[k];
    end
    chk("fault event", exp, seen);
    pg[k] <= 1'b1;
  endtask
  task automatic t_fault;
    for (int k = 0; k < 4; k += 3) begin
      wr_ok(CTL[k], 8'h82);
      watch(k, 1'b1);
      wr_ok(CTL[k], 8'h80);
      watch(k, 1'b0);
      wr_ok(CTL[k], 8'h02);
      watch(k, 1'b0);
    end
    $display("test fault done");
  endtask
  task automatic t_misc;
    uv <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("lockout", 0, {buck, ldo});
    uv <= 1'b0;
    rchk(8'h22, 8'h01);
    rchk(8'h30, 8'h00);
    host.wr(DEV ^ 7'h01, 8'h22, 8'h80, ok);
    chk("foreign ack", 0, ok);
    chk("on", 0, buck[0].on);
    rchk(8'h23, 8'h00);
    $display("test misc done");
  endtask
  initial begin
    rstn = 1'b0;
    bank = 1'b0;
    uv = 1'b0;
    pg = '1;
    cyc = 0;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("reset outputs", 0, {buck, ldo});
    rchk(8'h22, 8'h01);
    t_ctl();
    t_vcode();
    t_bleed();
    t_fault();
    t_misc();
    final_report();
  end
endmodule
`default_nettype wire
